// file: bench/bus_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_peer_model
(
   // Clock
   input wire logic i_clk,
   // Strobes from the device
   input wire logic i_storage_strobe_n,
   input wire logic i_io_enable_strobe_n,
   input wire logic i_write_n,
   // Vector offered in the acknowledge
   input wire logic [7:0] i_vector,
   output logic [7:0] o_data
);
   logic [7:0] last_q = 8'h00;
   logic mem_dly_n_q = 1'b1;
   // Storage strobe seen half a bus state late, as slow memory would
   always_ff @(posedge i_clk)
   begin
      last_q <= o_data;
      mem_dly_n_q <= i_storage_strobe_n;
   end
   // Memory adds no waits of its own and is never asked for more
   // Bus is released as each strobe ends (memory one clock later), so no recovery wait is needed
   // Released bus toggles so a stale byte is never mistaken for data
   always_comb
   begin
      if (!i_io_enable_strobe_n && i_write_n)
         o_data = i_vector;
      else if (!mem_dly_n_q && i_write_n)
         o_data = 8'h00;
      else
         o_data = ~last_q;
   end
endmodule
`default_nettype wire

// file: bench/mode0_ack_bus_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mode0_ack_bus_tb_top;
   import ack_bus_pkg::*;
   logic i_clk, i_rst_b, irq_n, mode0, sel_lo, sel_hi;
   logic [7:0] data, vector, odata, opc, hi_b, lo_b;
   logic [19:0] addr, addr_oe;
   logic [15:0] pc, ret;
   logic data_oe, mem_n, io_n, leg_n, wr_n, ack;
   int n_errors, checks, k, w, n;

   mode0_ack_bus i_mode0_ack_bus (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_ext_irq_zero_n(irq_n), .i_mode0(mode0),
      .i_ack_wait_sel_lo(sel_lo), .i_ack_wait_sel_hi(sel_hi),
      .i_data(data), .o_addr(addr), .o_addr_oe(addr_oe), .o_data(odata),
      .o_data_oe(data_oe), .o_storage_strobe_n(mem_n),
      .o_io_enable_strobe_n(io_n), .o_legacy_io_request_strobe_n(leg_n),
      .o_write_n(wr_n), .o_ack_active(ack), .o_pc(pc), .o_opcode(opc));

   bus_peer_model i_bus_peer_model (.i_clk(i_clk),
      .i_storage_strobe_n(mem_n), .i_io_enable_strobe_n(io_n),
      .i_write_n(wr_n), .i_vector(vector), .o_data(data));

   initial
   begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   task automatic final_report();
      if (n_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One clock, then inputs move just after the edge
   task automatic guard(inout int cnt);
      @(posedge i_clk);
      #1;
      cnt++;
      if (cnt > 300)
      begin
         n_errors++;
         $display("[FAIL] wait bound expected 300 seen %0d", cnt);
         final_report();
      end
   endtask

   task automatic do_ack(input logic [7:0] vec, input logic [1:0] sel);
      logic push;
      push = ((vec & OP_RESTART_MASK) == OP_RESTART_VAL) || (vec == OP_CALL);
      vector = vec;
      {sel_hi, sel_lo} = sel;
      irq_n = 1'b0;
      k = 0;
      while (ack !== 1'b1) guard(k);
      ret = pc;
      irq_n = 1'b1;
      k = 0;
      while (io_n !== 1'b0) guard(k);
      n = 0;
      while (leg_n !== 1'b0) guard(n);
      check("legacy strobe lag", n, 1);
      w = (int'(sel) + int'(ACK_BASE_WAITS)) % 4;
      n = 1;
      while (io_n !== 1'b1) guard(n);
      check("ack strobe length", n, 5 + 2 * w);
      check("pc in vector fetch", pc, ret);
      check("opcode taken", opc, vec);
      if (push)
      begin
         k = 0;
         while (wr_n !== 1'b0) guard(k);
         check("data drive", data_oe, 1'b1);
         hi_b = odata;
         k = 0;
         while (wr_n === 1'b0)
         begin
            lo_b = odata;
            guard(k);
         end
         check("stacked return", {hi_b, lo_b},
            ret + ((vec == OP_CALL) ? PC_TWO : 16'h0000));
      end
      else
      begin
         check("no stack write", wr_n, 1'b1);
         check("no data drive", data_oe, 1'b0);
      end
      k = 0;
      while (ack !== 1'b0) guard(k);
   endtask

   initial
   begin
      n_errors = 0;
      checks = 0;
      i_rst_b = 1'b0;
      irq_n = 1'b1;
      mode0 = 1'b1;
      {sel_hi, sel_lo} = WAIT_SEL_RESET;
      vector = DATA_RESET;
      void'($urandom(62));
      repeat (10) @(posedge i_clk);
      #1;
      check("address drive in reset", addr_oe, 20'h00000);
      repeat (10) @(posedge i_clk);
      #1;
      i_rst_b = 1'b1;
      k = 0;
      while (mem_n !== 1'b0) guard(k);
      check("first fetch", addr, RESTART_ADDR);
      check("address drive", addr_oe, 20'hFFFFF);
      // Plain fetches walk through memory one byte each
      for (int f = 1; f < 4; f++)
      begin
         k = 0;
         while (mem_n !== 1'b1) guard(k);
         while (mem_n !== 1'b0) guard(k);
         check("fetch address", addr, 20'(f));
      end
      // Every wait select with restart, call and a plain vector
      for (int i = 0; i < 12; i++)
      begin
         if (i % 3 == 1)
            do_ack(OP_CALL, 2'(i));
         else if (i % 3 == 0)
            do_ack(OP_RESTART_VAL | 8'(($urandom % 8) << 3), 2'(i));
         else
            do_ack(8'($urandom % 32'hC0), 2'(i));
         repeat (1 + $urandom % 8) @(posedge i_clk);
         #1;
      end
      // Reset again mid-run: bus floats, then restarts at the bottom
      i_rst_b = 1'b0;
      repeat (4) @(posedge i_clk);
      #1;
      check("address drive in reset", addr_oe, 20'h00000);
      check("pc in reset", pc, PC_RESET);
      i_rst_b = 1'b1;
      k = 0;
      while (mem_n !== 1'b0) guard(k);
      check("restart fetch", addr, RESTART_ADDR);
      // Not in mode 0: the request must not start an acknowledge
      mode0 = 1'b0;
      irq_n = 1'b0;
      repeat (40)
      begin
         @(posedge i_clk);
         #1;
         check("ack without mode 0", ack, 1'b0);
      end
      final_report();
   end
endmodule
`default_nettype wire

// file: shared/ack_bus_pkg.sv
package ack_bus_pkg;
   // Timing and encodings
   localparam logic [19:0] RESTART_ADDR = 20'h00000;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] SP_RESET = 16'hFFFF;
   localparam logic [1:0] WAIT_SEL_RESET = 2'h0;
   localparam logic [7:0] OP_RESTART_MASK = 8'hC7;
   localparam logic [7:0] OP_RESTART_VAL = 8'hC7;
   localparam logic [7:0] OP_CALL = 8'hCD;
   localparam logic [15:0] PC_ONE = 16'h0001;
   localparam logic [15:0] PC_TWO = 16'h0002;
   localparam logic [1:0] ACK_BASE_WAITS = 2'h2;
   localparam logic [7:0] DATA_RESET = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_T1 = 3'b001,
      ST_T2 = 3'b011,
      ST_TW = 3'b010,
      ST_T3 = 3'b110,
      ST_PUSH_HI = 3'b111,
      ST_PUSH_LO = 3'b101
   } bus_state_t;

   typedef enum logic [1:0] {
      CYC_OPCODE = 2'h0,
      CYC_OPERAND = 2'h1,
      CYC_IO = 2'h2
   } cyc_kind_t;
endpackage

// file: shared/strobe_if.sv
`timescale 1ns/1ps
`default_nettype none
interface strobe_if;
   logic phase_lo;
   logic io_cycle;
   logic in_t1;
   logic io_enable_strobe_n;
   logic legacy_io_request_strobe_n;
   modport gen (input phase_lo, io_cycle, in_t1,
      output io_enable_strobe_n, legacy_io_request_strobe_n);
   modport core (output phase_lo, io_cycle, in_t1,
      input io_enable_strobe_n, legacy_io_request_strobe_n);
endinterface
`default_nettype wire

// file: src/io_strobe_gen.sv
`timescale 1ns/1ps
`default_nettype none
module io_strobe_gen
   import ack_bus_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Strobe timing
   strobe_if.gen s
);
   typedef struct packed {
      logic en_n;
      logic leg_n;
   } strobe_state_t;

   strobe_state_t st_q;
   strobe_state_t st_d;

   always_comb
   begin
      st_d = st_q;
      // Falls as T2 begins, one clock ahead of the legacy strobe
      st_d.en_n = !(s.io_cycle && !(s.in_t1 && !s.phase_lo));
      st_d.leg_n = !(s.io_cycle && !s.in_t1);
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         st_q <= '{en_n: 1'b1, leg_n: 1'b1};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign s.io_enable_strobe_n = st_q.en_n;
   assign s.legacy_io_request_strobe_n = st_q.leg_n;

   a_strobe_lead: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      $fell(st_q.leg_n) |-> !$past(st_q.en_n))
      else $error("io enable strobe did not lead legacy strobe");
endmodule
`default_nettype wire

// file: src/mode0_ack_bus.sv
`timescale 1ns/1ps
`default_nettype none
module mode0_ack_bus
   import ack_bus_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Interrupt request and configuration
   input wire logic i_ext_irq_zero_n,
   input wire logic i_mode0,
   input wire logic i_ack_wait_sel_lo,
   input wire logic i_ack_wait_sel_hi,
   // Data bus from memory or vector source
   input wire logic [7:0] i_data,
   // Address bus
   output logic [19:0] o_addr,
   output logic [19:0] o_addr_oe,
   // Data bus drive for stacking
   output logic [7:0] o_data,
   output logic o_data_oe,
   // Strobes
   output logic o_storage_strobe_n,
   output logic o_io_enable_strobe_n,
   output logic o_legacy_io_request_strobe_n,
   output logic o_write_n,
   // Status
   output logic o_ack_active,
   output logic [15:0] o_pc,
   output logic [7:0] o_opcode
);
   logic [1:0] rst_sync_q;
   logic rst_b;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rst_sync_q <= 2'h0;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_b = rst_sync_q[1];

   typedef struct packed {
      bus_state_t st;
      logic phase_lo;
      cyc_kind_t kind;
      logic ack;
      logic first_fetch;
      logic [1:0] ops_left;
      logic [1:0] waits_left;
      logic [15:0] pc;
      logic [15:0] sp;
      logic [7:0] opcode;
      logic [7:0] data;
      logic started;
   } core_state_t;

   localparam core_state_t CORE_RESET = '{st: ST_IDLE, phase_lo: 1'b0,
      kind: CYC_OPCODE, ack: 1'b0, first_fetch: 1'b0, ops_left: 2'h0,
      waits_left: 2'h0, pc: PC_RESET, sp: SP_RESET, opcode: DATA_RESET,
      data: DATA_RESET, started: 1'b0};

   core_state_t c_q;
   core_state_t c_d;

   strobe_if sif ();

   // Wait count decode shared by start and assertion
   function automatic logic [1:0] ack_waits(input logic hi, input logic lo);
      ack_waits = {hi, lo};
   endfunction

   function automatic logic is_restart(input logic [7:0] op);
      is_restart = (op & OP_RESTART_MASK) == OP_RESTART_VAL;
   endfunction

   // ----------------------------------------------------------------
   // Bus sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      c_d = c_q;
      // One bus state spans two clocks: the high and low half of phi
      c_d.phase_lo = !c_q.phase_lo;
      if (c_q.phase_lo)
      begin
         case (c_q.st)
            ST_IDLE:
            begin
               c_d.st = ST_T1;
               c_d.kind = CYC_OPCODE;
               c_d.started = 1'b1;
               if (!i_ext_irq_zero_n && i_mode0 && c_q.started)
               begin
                  // Acknowledge fetch: vector read on io strobe
                  c_d.ack = 1'b1;
                  c_d.first_fetch = 1'b1;
                  c_d.kind = CYC_IO;
                  c_d.waits_left = ack_waits(i_ack_wait_sel_hi,
                     i_ack_wait_sel_lo) + ACK_BASE_WAITS;
               end
               else
               begin
                  c_d.ack = 1'b0;
                  c_d.waits_left = 2'h0;
               end
            end
            ST_T1:
            begin
               c_d.st = ST_T2;
            end
            ST_T2:
            begin
               c_d.st = (c_q.waits_left != 2'h0) ? ST_TW : ST_T3;
            end
            ST_TW:
            begin
               c_d.waits_left = c_q.waits_left - 2'h1;
               if (c_q.waits_left == 2'h1)
               begin
                  c_d.st = ST_T3;
               end
            end
            ST_T3:
            begin
               c_d.data = i_data;
               if (c_q.first_fetch)
               begin
                  // Vector opcode taken from the bus, counter frozen
                  c_d.opcode = i_data;
                  c_d.first_fetch = 1'b0;
                  c_d.kind = CYC_OPERAND;
                  if (is_restart(i_data))
                  begin
                     c_d.st = ST_PUSH_HI;
                  end
                  else if (i_data == OP_CALL)
                  begin
                     c_d.ops_left = 2'h2;
                     c_d.st = ST_T1;
                  end
                  else
                  begin
                     c_d.ack = 1'b0;
                     c_d.st = ST_IDLE;
                  end
                  c_d.waits_left = 2'h0;
               end
               else
               begin
                  c_d.pc = c_q.pc + PC_ONE;
                  if (c_q.kind == CYC_OPCODE)
                  begin
                     c_d.opcode = i_data;
                     c_d.st = ST_IDLE;
                  end
                  else if (c_q.ops_left == 2'h1)
                  begin
                     c_d.ops_left = 2'h0;
                     c_d.st = ST_PUSH_HI;
                  end
                  else
                  begin
                     c_d.ops_left = c_q.ops_left - 2'h1;
                     c_d.st = ST_T1;
                  end
               end
            end
            ST_PUSH_HI:
            begin
               c_d.sp = c_q.sp - PC_ONE;
               c_d.st = ST_PUSH_LO;
            end
            ST_PUSH_LO:
            begin
               c_d.sp = c_q.sp - PC_ONE;
               c_d.ack = 1'b0;
               c_d.st = ST_IDLE;
            end
            default:
            begin
               c_d.st = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         c_q <= CORE_RESET;
      end
      else
      begin
         c_q <= c_d;
      end
   end

   // ----------------------------------------------------------------
   // Strobes and bus drive
   // ----------------------------------------------------------------
   assign sif.phase_lo = c_q.phase_lo;
   assign sif.io_cycle = (c_q.kind == CYC_IO) && (c_q.st == ST_T1 ||
      c_q.st == ST_T2 || c_q.st == ST_TW || c_q.st == ST_T3);
   assign sif.in_t1 = (c_q.st == ST_T1);

   io_strobe_gen u_strobe (
      .i_clk(i_clk),
      .i_rst_b(rst_b),
      .s(sif.gen)
   );

   logic mem_cycle;
   logic push_cycle;
   assign mem_cycle = (c_q.kind != CYC_IO) && (c_q.st == ST_T2 ||
      c_q.st == ST_TW || c_q.st == ST_T3);
   assign push_cycle = (c_q.st == ST_PUSH_HI) || (c_q.st == ST_PUSH_LO);

   // Idle address bus still driven: only reset floats it
   assign o_addr = (c_q.st == ST_IDLE && !c_q.started) ? RESTART_ADDR :
      (push_cycle ? {4'h0, c_q.sp} : {4'h0, c_q.pc});
   assign o_addr_oe = rst_b ? 20'hFFFFF : 20'h00000;
   assign o_data = (c_q.st == ST_PUSH_HI) ? c_q.pc[15:8] : c_q.pc[7:0];
   assign o_data_oe = push_cycle;
   assign o_storage_strobe_n = !(mem_cycle || push_cycle);
   assign o_write_n = !push_cycle;
   assign o_io_enable_strobe_n = sif.io_enable_strobe_n;
   assign o_legacy_io_request_strobe_n = sif.legacy_io_request_strobe_n;
   assign o_ack_active = c_q.ack;
   assign o_pc = c_q.pc;
   assign o_opcode = c_q.opcode;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_pc_frozen_ack: assert property (@(posedge i_clk) disable iff (!rst_b)
      (c_q.first_fetch && c_q.st == ST_T3 && c_q.phase_lo)
      |=> $stable(c_q.pc))
      else $error("counter moved during acknowledge opcode fetch");
   a_pc_normal_inc: assert property (@(posedge i_clk) disable iff (!rst_b)
      (!c_q.first_fetch && c_q.st == ST_T3 && c_q.phase_lo)
      |=> c_q.pc == $past(c_q.pc) + PC_ONE)
      else $error("counter not bumped on fetch");
   a_vector_exec: assert property (@(posedge i_clk) disable iff (!rst_b)
      (c_q.first_fetch && c_q.st == ST_T3 && c_q.phase_lo)
      |=> c_q.opcode == $past(i_data))
      else $error("vector opcode not taken from bus");
   a_restart_push: assert property (@(posedge i_clk) disable iff (!rst_b)
      (c_q.first_fetch && c_q.st == ST_T3 && c_q.phase_lo &&
      is_restart(i_data)) |=> c_q.st == ST_PUSH_HI)
      else $error("restart did not push at once");
   a_call_plus_two: assert property (@(posedge i_clk) disable iff (!rst_b)
      (c_q.first_fetch && c_q.st == ST_T3 && c_q.phase_lo &&
      i_data == OP_CALL) |=> c_q.ops_left == 2'h2)
      else $error("call did not read two operands");
   a_ack_waits: assert property (@(posedge i_clk) disable iff (!rst_b)
      (c_q.st == ST_IDLE && c_q.phase_lo && c_d.ack && c_d.first_fetch)
      |=> c_q.waits_left == ack_waits($past(i_ack_wait_sel_hi),
      $past(i_ack_wait_sel_lo)) + ACK_BASE_WAITS)
      else $error("acknowledge wait count wrong");
   a_first_fetch_zero: assert property (@(posedge i_clk) disable iff (!rst_b)
      $rose(c_q.started) |-> o_addr == RESTART_ADDR)
      else $error("first fetch not at restart address");
   a_addr_float: assert property (@(posedge i_clk)
      !rst_b |-> o_addr_oe == 20'h00000)
      else $error("address driven during reset");
endmodule
`default_nettype wire
